// file: verilog/paged_twowire_register_port.sv
/*
  Slave two-wire port giving access to the 16-bit configuration registers,
  the write bit mask, the page select and the paged register window.
  Assumes scl/sda, the mode strap and the address straps are asynchronous
  to clock; paged register storage lives outside and answers rd_data for
  the page/offset this block presents, within two clocks.

// Summary of operation
// - serial clock up to 100 kbps standard and 400 kbps fast rate
// - bytes travel msb first, one scl pulse per bit, change while low
// - receiver pulls sda low in ninth pulse to acknowledge; high is nack
// - first byte is seven-bit slave address plus direction, zero writes
// - acknowledge address only on own match, otherwise ignore transfer
// - second write byte is the eight-bit register address
// - registers are 16 bits; third byte high half, fourth low half
// - register updates only after the low byte is acknowledged
// - read data driven each falling scl, high byte then low byte
// - release sda after eighth falling edge; master clocks the ack
// - port works only while the mode strap is tied low
// - two tri-level straps pick address 0x10 to 0x17; both high reserved
// - mask register at 0x7E: ones let bits be written, zeros keep them
// - page select at 0x7F chooses what 0x80 to 0xFF reaches
// - 0x00 to 0x7F reachable on any page; 0x00 to 0x7D reserved
// - pages: channels, eye monitors, two synthesizers, digital core
// - pages 0x50, 0x60, 0x70 broadcast writes and cannot be read
// - power-on reset clears the control registers to zero
*/
`timescale 1ns/1ps

module paged_twowire_register_port
  import twowire_port_pkg::*;
(
  input  wire logic                 clock,           // 250 MHz core clock
  input  wire logic                 rst,             // async, active high
  input  wire logic                 scl_in,          // serial clock pin
  input  wire logic                 sda_in,          // serial data pin level
  output logic                      sda_out,         // data pin drive value
  output logic                      sda_oe_n,        // low drives sda
  input  wire logic                 mode_strap,      // low enables port
  input  wire logic [1:0]           addr_strap_high, // tri-level code
  input  wire logic [1:0]           addr_strap_low,  // tri-level code
  output logic [7:0]                rd_page,         // page being read
  output logic [6:0]                rd_offset,       // offset being read
  output logic                      rd_strobe,       // read data taken
  input  wire logic [15:0]          rd_data,         // paged read value
  output logic [NUM_CHAN-1:0]       wr_chan_en,      // channel write pulse
  output logic [NUM_CHAN-1:0]       wr_eye_en,       // eye-monitor pulse
  output logic [NUM_SYNTH-1:0]      wr_synth_en,     // synthesizer pulse
  output logic                      wr_core_en,      // core write pulse
  output logic [6:0]                wr_offset,       // offset in page
  output logic [15:0]               wr_data,         // value to store
  output logic [15:0]               wr_bit_en,       // per-bit write enable
  output logic [15:0]               mask_value,      // write bit mask
  output logic [15:0]               page_value       // page select
);

  localparam int WR_SEL_W = 2 * NUM_CHAN + NUM_SYNTH + 1;

  // write target decode: {core, synth, eye, chan}
  function automatic logic [WR_SEL_W-1:0] write_targets(
    input logic [15:0] page
  );
    logic [NUM_CHAN-1:0]  chan;
    logic [NUM_CHAN-1:0]  eye;
    logic [NUM_SYNTH-1:0] synth;
    logic                 core;
    logic [7:0]           p;
    chan  = '0;
    eye   = '0;
    synth = '0;
    core  = 1'b0;
    p     = page[7:0];
    if (page[15:8] == 8'h00) begin
      if (p <= CHAN_PAGE_LAST)
        chan = NUM_CHAN'(1) << p[3:0];
      else if (p >= EYE_PAGE_FIRST && p <= EYE_PAGE_LAST)
        eye = NUM_CHAN'(1) << p[3:0];
      else if (p == SYNTH0_PAGE || p == SYNTH1_PAGE)
        synth = NUM_SYNTH'(1) << p[0];
      else if (p == CORE_PAGE)
        core = 1'b1;
      else if (p == CHAN_BCAST_PAGE)
        chan = '1;
      else if (p == EYE_BCAST_PAGE)
        eye = '1;
      else if (p == SYNTH_BCAST_PAGE)
        synth = '1;
    end
    // any other page, the test page among them, reaches nothing
    write_targets = {core, synth, eye, chan};
  endfunction

  // broadcast and reserved pages are not readable
  function automatic logic page_readable(input logic [15:0] page);
    logic [7:0] p;
    p = page[7:0];
    page_readable = (page[15:8] == 8'h00) &&
                    ((p <= CHAN_PAGE_LAST) ||
                     (p >= EYE_PAGE_FIRST && p <= EYE_PAGE_LAST) ||
                     (p == SYNTH0_PAGE) || (p == SYNTH1_PAGE) ||
                     (p == CORE_PAGE));
  endfunction

  // slot index of a tri-level strap pair; codes beyond high are invalid
  function automatic logic [3:0] strap_slot(
    input logic [1:0] hi,
    input logic [1:0] lo
  );
    strap_slot = 4'(({2'b00, hi} * 4'h3) + {2'b00, lo});
  endfunction

  // synchroniser stages; the first of each pair feeds only the second
  logic        scl_meta_reg;
  logic        scl_sync_reg;
  logic        scl_prev_reg;
  logic        sda_meta_reg;
  logic        sda_sync_reg;
  logic        sda_prev_reg;
  logic        mode_meta_reg;
  logic        mode_sync_reg;
  logic [3:0]  strap_meta_reg;
  logic [3:0]  strap_sync_reg;

  // protocol state
  port_state_t state_reg;
  port_state_t state_next;
  logic [3:0]  bit_cnt_reg;
  logic [3:0]  bit_cnt_next;
  logic [2:0]  byte_idx_reg;
  logic [2:0]  byte_idx_next;
  logic        rd_mode_reg;
  logic        rd_mode_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [7:0]  tx_shift_reg;
  logic [7:0]  tx_shift_next;
  logic [7:0]  tx_low_reg;
  logic [7:0]  tx_low_next;
  logic        tx_half_reg;
  logic        tx_half_next;
  logic        master_ack_reg;
  logic        master_ack_next;
  logic [7:0]  reg_addr_reg;
  logic [7:0]  reg_addr_next;
  logic [7:0]  data_hi_reg;
  logic [7:0]  data_hi_next;
  logic [7:0]  data_lo_reg;
  logic [7:0]  data_lo_next;
  logic        sda_oe_n_reg;
  logic        sda_oe_n_next;
  logic        commit_reg;
  logic        commit_next;

  // register file and outward write port
  logic [15:0]         mask_reg;
  logic [15:0]         mask_next;
  logic [15:0]         page_reg;
  logic [15:0]         page_next;
  logic [WR_SEL_W-1:0] wr_sel_reg;
  logic [WR_SEL_W-1:0] wr_sel_next;
  logic [6:0]          wr_offset_reg;
  logic [15:0]         wr_data_reg;
  logic [15:0]         wr_bit_en_reg;
  logic [7:0]          rd_page_reg;
  logic [6:0]          rd_offset_reg;
  logic                rd_strobe_reg;
  logic                rd_strobe_next;

  // two-flop synchronisers, plus one history stage for edge finding
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_meta_reg   <= 1'b1;
      scl_sync_reg   <= 1'b1;
      scl_prev_reg   <= 1'b1;
      sda_meta_reg   <= 1'b1;
      sda_sync_reg   <= 1'b1;
      sda_prev_reg   <= 1'b1;
      mode_meta_reg  <= 1'b1;
      mode_sync_reg  <= 1'b1;
      strap_meta_reg <= 4'h0;
      strap_sync_reg <= 4'h0;
    end else begin
      scl_meta_reg   <= scl_in;
      scl_sync_reg   <= scl_meta_reg;
      scl_prev_reg   <= scl_sync_reg;
      sda_meta_reg   <= sda_in;
      sda_sync_reg   <= sda_meta_reg;
      sda_prev_reg   <= sda_sync_reg;
      mode_meta_reg  <= mode_strap;
      mode_sync_reg  <= mode_meta_reg;
      strap_meta_reg <= {addr_strap_high, addr_strap_low};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // bus events; a start or stop needs scl high on two samples in a row
  wire scl_rise   = scl_sync_reg & ~scl_prev_reg;
  wire scl_fall   = ~scl_sync_reg & scl_prev_reg;
  wire start_cond = scl_sync_reg & scl_prev_reg &
                    sda_prev_reg & ~sda_sync_reg;
  wire stop_cond  = scl_sync_reg & scl_prev_reg &
                    ~sda_prev_reg & sda_sync_reg;
  wire port_en    = ~mode_sync_reg;

  // own address from the straps; the both-high slot answers nothing
  wire [3:0] slot      = strap_slot(strap_sync_reg[3:2],
                                    strap_sync_reg[1:0]);
  wire       own_valid = (strap_sync_reg[3:2] <= STRAP_HIGH) &&
                         (strap_sync_reg[1:0] <= STRAP_HIGH) &&
                         (slot < SLAVE_ADDR_SLOTS);
  wire [6:0] own_addr  = BASE_SLAVE_ADDR + {4'h0, slot[2:0]};
  wire       addr_hit  = own_valid &&
                         (shift_reg[7:1] == own_addr);

  // read value; reserved registers and unreadable pages give zero
  wire [15:0] read_word =
    (reg_addr_reg == MASK_REG_ADDR) ? mask_reg :
    (reg_addr_reg == PAGE_REG_ADDR) ? page_reg :
    (reg_addr_reg[7] && page_readable(page_reg)) ? rd_data :
    16'h0000;

  wire [15:0] write_word = {data_hi_reg, data_lo_reg};

  // protocol sequencing
  always_comb begin
    state_next      = state_reg;
    bit_cnt_next    = bit_cnt_reg;
    byte_idx_next   = byte_idx_reg;
    rd_mode_next    = rd_mode_reg;
    shift_next      = shift_reg;
    tx_shift_next   = tx_shift_reg;
    tx_low_next     = tx_low_reg;
    tx_half_next    = tx_half_reg;
    master_ack_next = master_ack_reg;
    reg_addr_next   = reg_addr_reg;
    data_hi_next    = data_hi_reg;
    data_lo_next    = data_lo_reg;
    sda_oe_n_next   = sda_oe_n_reg;
    commit_next     = 1'b0;
    rd_strobe_next  = 1'b0;
    if (!port_en) begin
      state_next    = st_idle;
      sda_oe_n_next = 1'b1;
    end else if (start_cond) begin
      // a start anywhere restarts framing; nothing is written
      state_next    = st_rx;
      bit_cnt_next  = 4'h0;
      byte_idx_next = 3'h0;
      sda_oe_n_next = 1'b1;
    end else if (stop_cond) begin
      state_next    = st_idle;
      sda_oe_n_next = 1'b1;
    end else begin
      case (state_reg)
        st_idle: begin
          sda_oe_n_next = 1'b1;
        end
        st_rx: begin
          if (scl_rise) begin
            shift_next   = {shift_reg[6:0], sda_sync_reg};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
            bit_cnt_next  = 4'h0;
            byte_idx_next = byte_idx_reg + 3'h1;
            state_next    = st_rx_ack;
            sda_oe_n_next = 1'b0;
            case (byte_idx_reg)
              3'h0: begin
                if (addr_hit) begin
                  rd_mode_next = (shift_reg[0] == DIR_READ);
                end else begin
                  state_next    = st_idle;
                  sda_oe_n_next = 1'b1;
                end
              end
              3'h1: reg_addr_next = shift_reg;
              3'h2: data_hi_next  = shift_reg;
              3'h3: data_lo_next  = shift_reg;
              default: begin
                // bytes past the low half are not acknowledged
                state_next    = st_idle;
                sda_oe_n_next = 1'b1;
              end
            endcase
          end
        end
        st_rx_ack: begin
          if (scl_fall) begin
            if (rd_mode_reg) begin
              // first falling edge after the ack carries the msb
              tx_shift_next  = {read_word[14:8], 1'b0};
              tx_low_next    = read_word[7:0];
              sda_oe_n_next  = read_word[15];
              tx_half_next   = 1'b0;
              bit_cnt_next   = 4'h1;
              rd_strobe_next = 1'b1;
              state_next     = st_tx;
            end else begin
              sda_oe_n_next = 1'b1;
              state_next    = st_rx;
              commit_next   = (byte_idx_reg == LAST_DATA_IDX);
            end
          end
        end
        st_tx: begin
          if (scl_fall) begin
            if (bit_cnt_reg == BYTE_BITS) begin
              sda_oe_n_next = 1'b1;
              state_next    = st_tx_ack;
            end else begin
              sda_oe_n_next = tx_shift_reg[7];
              tx_shift_next = {tx_shift_reg[6:0], 1'b0};
              bit_cnt_next  = bit_cnt_reg + 4'h1;
            end
          end
        end
        st_tx_ack: begin
          if (scl_rise) begin
            master_ack_next = ~sda_sync_reg;
          end else if (scl_fall) begin
            if (master_ack_reg && !tx_half_reg) begin
              tx_shift_next = {tx_low_reg[6:0], 1'b0};
              sda_oe_n_next = tx_low_reg[7];
              tx_half_next  = 1'b1;
              bit_cnt_next  = 4'h1;
              state_next    = st_tx;
            end else begin
              // nack or end of word: wait quietly for the stop
              sda_oe_n_next = 1'b1;
              state_next    = st_idle;
            end
          end
        end
        default: begin
          state_next    = st_idle;
          sda_oe_n_next = 1'b1;
        end
      endcase
    end
  end

  // the mask guards paged writes only, so a zero mask cannot lock it out
  wire is_mask_wr  = commit_reg && (reg_addr_reg == MASK_REG_ADDR);
  wire is_page_wr  = commit_reg && (reg_addr_reg == PAGE_REG_ADDR);
  wire is_paged_wr = commit_reg && reg_addr_reg[7];

  // register file updates; writes below 0x7E fall away
  assign mask_next   = is_mask_wr ? write_word : mask_reg;
  assign page_next   = is_page_wr ? write_word : page_reg;
  assign wr_sel_next = is_paged_wr ? write_targets(page_reg)
                                   : '0;

  // protocol registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg      <= st_idle;
      bit_cnt_reg    <= 4'h0;
      byte_idx_reg   <= 3'h0;
      rd_mode_reg    <= 1'b0;
      shift_reg      <= 8'h00;
      tx_shift_reg   <= 8'h00;
      tx_low_reg     <= 8'h00;
      tx_half_reg    <= 1'b0;
      master_ack_reg <= 1'b0;
      reg_addr_reg   <= 8'h00;
      data_hi_reg    <= 8'h00;
      data_lo_reg    <= 8'h00;
      sda_oe_n_reg   <= 1'b1;
      commit_reg     <= 1'b0;
      rd_strobe_reg  <= 1'b0;
    end else begin
      state_reg      <= state_next;
      bit_cnt_reg    <= bit_cnt_next;
      byte_idx_reg   <= byte_idx_next;
      rd_mode_reg    <= rd_mode_next;
      shift_reg      <= shift_next;
      tx_shift_reg   <= tx_shift_next;
      tx_low_reg     <= tx_low_next;
      tx_half_reg    <= tx_half_next;
      master_ack_reg <= master_ack_next;
      reg_addr_reg   <= reg_addr_next;
      data_hi_reg    <= data_hi_next;
      data_lo_reg    <= data_lo_next;
      sda_oe_n_reg   <= sda_oe_n_next;
      commit_reg     <= commit_next;
      rd_strobe_reg  <= rd_strobe_next;
    end
  end

  // register file and outward write port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_reg      <= MASK_RESET;
      page_reg      <= PAGE_RESET;
      wr_sel_reg    <= '0;
      wr_offset_reg <= 7'h00;
      wr_data_reg   <= 16'h0000;
      wr_bit_en_reg <= 16'h0000;
      rd_page_reg   <= 8'h00;
      rd_offset_reg <= 7'h00;
    end else begin
      mask_reg      <= mask_next;
      page_reg      <= page_next;
      wr_sel_reg    <= wr_sel_next;
      wr_offset_reg <= is_paged_wr ? reg_addr_reg[6:0] : wr_offset_reg;
      wr_data_reg   <= is_paged_wr ? write_word : wr_data_reg;
      wr_bit_en_reg <= is_paged_wr ? mask_reg : wr_bit_en_reg;
      rd_page_reg   <= page_reg[7:0];
      rd_offset_reg <= reg_addr_reg[6:0];
    end
  end

  // outputs straight from flip-flops, sda_out tied low; the pin only ever pulls low
  assign sda_out     = 1'b0;
  assign sda_oe_n    = sda_oe_n_reg;
  assign rd_page     = rd_page_reg;
  assign rd_offset   = rd_offset_reg;
  assign rd_strobe   = rd_strobe_reg;
  assign wr_chan_en  = wr_sel_reg[NUM_CHAN-1:0];
  assign wr_eye_en   = wr_sel_reg[2*NUM_CHAN-1:NUM_CHAN];
  assign wr_synth_en = wr_sel_reg[2*NUM_CHAN+NUM_SYNTH-1:2*NUM_CHAN];
  assign wr_core_en  = wr_sel_reg[WR_SEL_W-1];
  assign wr_offset   = wr_offset_reg;
  assign wr_data     = wr_data_reg;
  assign wr_bit_en   = wr_bit_en_reg;
  assign mask_value  = mask_reg;
  assign page_value  = page_reg;

endmodule // paged_twowire_register_port

// file: verilog/twowire_port_pkg.sv
/*
  Constants and types for the paged two-wire register port.
  Assumes a single core clock domain; the serial pins are asynchronous.
*/
package twowire_port_pkg;

  // register map below the paged window
  localparam logic [7:0]  MASK_REG_ADDR    = 8'h7E;
  localparam logic [7:0]  PAGE_REG_ADDR    = 8'h7F;
  localparam logic [15:0] MASK_RESET       = 16'h0000;
  localparam logic [15:0] PAGE_RESET       = 16'h0000;

  // page select values
  localparam logic [7:0]  CHAN_PAGE_LAST   = 8'h0B;
  localparam logic [7:0]  EYE_PAGE_FIRST   = 8'h20;
  localparam logic [7:0]  EYE_PAGE_LAST    = 8'h2B;
  localparam logic [7:0]  SYNTH0_PAGE      = 8'h30;
  localparam logic [7:0]  SYNTH1_PAGE      = 8'h31;
  localparam logic [7:0]  CORE_PAGE        = 8'h40;
  localparam logic [7:0]  CHAN_BCAST_PAGE  = 8'h50;
  localparam logic [7:0]  EYE_BCAST_PAGE   = 8'h60;
  localparam logic [7:0]  SYNTH_BCAST_PAGE = 8'h70;
  localparam logic [7:0]  TEST_PAGE        = 8'h80;

  // serial framing
  localparam logic [6:0]  BASE_SLAVE_ADDR  = 7'h10;
  localparam logic [3:0]  SLAVE_ADDR_SLOTS = 4'h8;
  localparam logic [3:0]  BYTE_BITS        = 4'h8;
  localparam logic [2:0]  LAST_DATA_IDX    = 3'h4;
  localparam logic        DIR_READ         = 1'b1;

  // tri-level strap codes from the pad detector
  localparam logic [1:0]  STRAP_LOW        = 2'h0;
  localparam logic [1:0]  STRAP_FLOAT      = 2'h1;
  localparam logic [1:0]  STRAP_HIGH       = 2'h2;

  localparam int          NUM_CHAN         = 12;
  localparam int          NUM_SYNTH        = 2;

  typedef enum logic [2:0] {
    st_idle,
    st_rx,
    st_rx_ack,
    st_tx,
    st_tx_ack
  } port_state_t;

endpackage

// file: tb/twowire_master.sv
/*
  Two-wire bus master model: drives scl and its own share of sda.
  Assumes an outside pull-up resolves sda from every open-drain driver.
*/
`timescale 1ns/1ps

module twowire_master (
  output logic      scl,   // serial clock, push-pull
  output logic      sda_m, // 0 pulls sda low
  input  wire logic sda    // resolved sda level
);
  time q = 12ns; // quarter bit; 48 ns bit runs far above fast rate
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // sda falls while scl high; doubles as repeated start
  // pins move by non-blocking update so the core flops never race them
  task automatic start();
    #q sda_m <= 1'b1;
    #q scl <= 1'b1;
    #q sda_m <= 1'b0;
    #q scl <= 1'b0;
  endtask
  // sda rises while scl high, bus left idle
  task automatic stop();
    #q sda_m <= 1'b0;
    #q scl <= 1'b1;
    #q sda_m <= 1'b1;
    #q;
  endtask
  // data moves only while scl low, sampled mid-high
  task automatic bitx(input logic b, output logic r);
    #q sda_m <= b;
    #q scl <= 1'b1;
    #q r = sda;
    #q scl <= 1'b0;
  endtask
  // msb first plus ack slot; a 1 releases the line to listen
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) bitx(tx[i], rx[i]);
  endtask
endmodule // twowire_master

// file: tb/paged_twowire_register_port_asserts.sv
/*
  Concurrent checks on the two-wire register port outputs.
  Assumes scl half periods of several core clocks.
*/
`timescale 1ns/1ps

module paged_twowire_register_port_asserts
  import twowire_port_pkg::*;
(
  input wire logic                 clock,       // core clock
  input wire logic                 rst,         // async reset
  input wire logic                 scl_in,      // serial clock pin
  input wire logic                 mode_strap,  // low enables port
  input wire logic                 sda_oe_n,    // low drives sda
  input wire logic                 rd_strobe,   // read capture pulse
  input wire logic [NUM_CHAN-1:0]  wr_chan_en,  // channel pulses
  input wire logic [NUM_CHAN-1:0]  wr_eye_en,   // eye pulses
  input wire logic [NUM_SYNTH-1:0] wr_synth_en, // synth pulses
  input wire logic                 wr_core_en,  // core pulse
  input wire logic [15:0]          wr_data,     // paged write value
  input wire logic [15:0]          wr_bit_en,   // paged bit enables
  input wire logic [15:0]          mask_value,  // write bit mask
  input wire logic [15:0]          page_value   // page select
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // any paged write pulse
  wire any_wr = |{wr_chan_en, wr_eye_en, wr_synth_en, wr_core_en};
  a_oe_mode_off: assert property (mode_strap [*6] |-> sda_oe_n)
    else $error("sda driven while port disabled");
  a_oe_scl_low: assert property (
    $changed(sda_oe_n) |-> !scl_in || mode_strap)
    else $error("sda drive moved while scl high");
  a_core_pulse: assert property (
    wr_core_en |-> page_value == 16'h0040 ##1 !wr_core_en)
    else $error("core write on wrong page or too long");
  a_chan_route: assert property (|wr_chan_en |-> (
    page_value == 16'h0050 ? &wr_chan_en : page_value < 16'h000C &&
    wr_chan_en == 12'h001 << page_value[3:0]))
    else $error("channel write routed wrongly");
  a_synth_route: assert property (wr_synth_en[0] |->
    page_value == 16'h0030 || page_value == 16'h0070)
    else $error("synthesizer write routed wrongly");
  a_bit_en_mask: assert property (any_wr |-> wr_bit_en == mask_value)
    else $error("bit enables differ from mask");
  a_data_cause: assert property ($changed(wr_data) |-> any_wr)
    else $error("write data moved without a write");
  a_reg_commit: assert property (
    $changed({mask_value, page_value}) |-> !scl_in && !$past(scl_in, 2))
    else $error("register changed outside a byte end");
  c_bcast: cover property (&wr_chan_en);
  c_read: cover property (rd_strobe);
  c_core: cover property (wr_core_en);
endmodule // paged_twowire_register_port_asserts

bind paged_twowire_register_port
  paged_twowire_register_port_asserts u_asserts (
  .clock, .rst, .scl_in, .mode_strap, .sda_oe_n, .rd_strobe, .wr_chan_en,
  .wr_eye_en, .wr_synth_en, .wr_core_en, .wr_data, .wr_bit_en,
  .mask_value, .page_value);

// file: tb/tb.sv
/*
  Self-checking bench for the paged two-wire register port.
  Assumes the master model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps

module tb
  import twowire_port_pkg::*;
;
  typedef struct packed {logic [7:0] pg; logic [26:0] rt; logic rd;} row_t;
  logic        clock, rst, mode_strap, sda_oe_n, sda_out, rd_strobe, ak, b;
  logic        scl, sda_m, wr_core_en, clr;
  logic [1:0]  addr_strap_high, addr_strap_low, wr_synth_en;
  logic [6:0]  rd_offset, wr_offset, da;
  logic [7:0]  rd_page;
  logic [8:0]  r;
  logic [11:0] wr_chan_en, wr_eye_en;
  logic [15:0] rd_data, wr_data, wr_bit_en, mask_value, page_value, v;
  logic [26:0] seen;
  int          error_cnt, total_checks, cyc, ns;
  wire         sda = (sda_oe_n | sda_out) & sda_m; // pulled-up wire
  // page, expected pulses {chan, eye, synth, core}, readable
  // the reserved test page 0x80 is never selected
  row_t rows [11] = '{'{8'h00, 27'h000_8000, 1}, '{8'h0B, 27'h400_0000, 1},
    '{8'h20, 27'h000_0008, 1}, '{8'h2B, 27'h000_4000, 1},
    '{8'h30, 27'h000_0002, 1}, '{8'h31, 27'h000_0004, 1},
    '{8'h40, 27'h000_0001, 1}, '{8'h50, 27'h7FF_8000, 0},
    '{8'h60, 27'h000_7FF8, 0}, '{8'h70, 27'h000_0006, 0},
    '{8'h0C, 27'h000_0000, 0}};
  paged_twowire_register_port u_paged_twowire_register_port (.clock, .rst,
    .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n, .mode_strap,
    .addr_strap_high, .addr_strap_low, .rd_page, .rd_offset, .rd_strobe,
    .rd_data, .wr_chan_en, .wr_eye_en, .wr_synth_en, .wr_core_en, .wr_offset,
    .wr_data, .wr_bit_en, .mask_value, .page_value);
  twowire_master u_twowire_master (.scl, .sda_m, .sda);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // paged storage stand-in and pulse capture; timeout cuts a hang
  always @(posedge clock) begin
    rd_data <= {rd_page, 1'b1, rd_offset};
    if (|{wr_chan_en, wr_eye_en, wr_synth_en, wr_core_en})
      seen <= {wr_chan_en, wr_eye_en, wr_synth_en, wr_core_en};
    else if (clr)
      seen <= '0;
    if (rd_strobe)
      ns++;
    cyc++;
    if (cyc == 60000) begin
      chk(0, 1);
      print_verdict();
    end
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ra, input logic [15:0] d, input int n);
    logic [7:0] bt [4];
    bt = '{{da, 1'b0}, ra, d[15:8], d[7:0]};
    ak = 1'b0;
    u_twowire_master.start();
    for (int i = 0; i < n; i++) begin
      u_twowire_master.xfer({bt[i], 1'b1}, r);
      ak |= r[0];
    end
    u_twowire_master.stop();
  endtask
  task automatic rd(input logic [7:0] ra);
    u_twowire_master.start();
    u_twowire_master.xfer({da, 2'b01}, r);
    ak = r[0];
    u_twowire_master.xfer({ra, 1'b1}, r);
    ak |= r[0];
    u_twowire_master.start();
    u_twowire_master.xfer({da, 2'b11}, r);
    ak |= r[0];
    u_twowire_master.xfer(9'h1FE, r);
    v[15:8] = r[8:1];
    u_twowire_master.xfer(9'h1FF, r);
    v[7:0] = r[8:1];
    u_twowire_master.stop();
  endtask
  task automatic probe(input logic [6:0] a, input logic nak);
    u_twowire_master.start();
    u_twowire_master.xfer({a, 2'b01}, r);
    u_twowire_master.stop();
    chk(r[0], nak);
  endtask
  initial begin
    rst = 1'b1;
    mode_strap = 1'b0;
    addr_strap_high = 2'h0;
    addr_strap_low = 2'h0;
    clr = 1'b0;
    da = 7'h10;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk({mask_value, page_value}, 0);
    wr(8'h7E, 16'hF0F0, 4);
    rd(8'h7E);
    chk({ak, v, mask_value}, {1'b0, 16'hF0F0, 16'hF0F0});
    foreach (rows[i]) begin
      wr(8'h7F, {8'h00, rows[i].pg}, 4);
      @(negedge clock) clr = 1'b1;
      @(negedge clock) clr = 1'b0;
      @(posedge clock);
      wr({1'b1, 7'(i)}, 16'hA5C3, 4);
      chk(seen, rows[i].rt);
      if (rows[i].rt != 0) chk({wr_offset, wr_data, wr_bit_en}, {7'(i), 32'hA5C3_F0F0});
      rd({1'b1, 7'(i)});
      chk({ak, v}, rows[i].rd ? {1'b0, rows[i].pg, 1'b1, 7'(i)} : 0);
      $display("page %h row done", rows[i].pg);
    end
    chk(ns, 12);
    for (int i = 0; i < 9; i++) begin
      addr_strap_high <= 2'(i / 3);
      addr_strap_low <= 2'(i % 3);
      repeat (4) @(posedge clock);
      probe(7'h10 + 7'(i), i == 8);
      probe(7'h17 - 7'(i), 1'b1);
    end
    addr_strap_high <= 2'h0;
    addr_strap_low <= 2'h3;
    repeat (4) @(posedge clock);
    probe(7'h13, 1'b1);
    addr_strap_low <= 2'h0;
    $display("address straps done");
    wr(8'h7E, 16'h1234, 3);
    u_twowire_master.start();
    u_twowire_master.xfer({da, 2'b01}, r);
    u_twowire_master.xfer(9'h0FD, r);
    repeat (4) u_twowire_master.bitx(1'b0, b);
    u_twowire_master.stop();
    chk(mask_value, 16'hF0F0);
    u_twowire_master.q = 40ns;
    wr(8'h7F, 16'h0031, 4);
    u_twowire_master.q = 12ns;
    chk({ak, page_value}, 16'h0031);
    wr(8'h10, 16'hFFFF, 4);
    rd(8'h10);
    chk({ak, v}, 0);
    mode_strap <= 1'b1;
    wr(8'h7E, 16'h0001, 4);
    chk({ak, mask_value}, {1'b1, 16'hF0F0});
    mode_strap <= 1'b0;
    $display("partial, abort, reserved, strap done");
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk({mask_value, page_value}, 0);
    $display("second reset done");
    print_verdict();
  end
endmodule // tb
